// *** hw/pss_core.sv ***
// Purpose: Storage array with per-lane writes and a registered read port
// Assumes: Caller gates enables with the clock qualifier
// Notes:   Contents survive sleep; there is no reset of the array
`timescale 1ns/10ps
`default_nettype none
`include "pss_map.svh"

module pss_core #(
  parameter int ADDR_W = `PSS_ADDR_W,
  parameter int LANES  = `PSS_LANES,
  parameter int LANE_W = `PSS_LANE_W
) (
  input  wire logic clk,
  pss_core_if.core  bus
);

  localparam int DEPTH = 1 << ADDR_W;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W-1:0] lane_mem [0:DEPTH-1];
    logic [LANE_W-1:0] rd_q;

    // Write timing is internal: the edge itself is the only strobe
    always_ff @(posedge clk) begin
      if (bus.wr_en && bus.lane_we[g]) begin
        lane_mem[bus.addr] <= bus.wdata[g*LANE_W +: LANE_W];
      end
    end

    always_ff @(posedge clk) begin
      if (bus.rd_en) begin
        rd_q <= lane_mem[bus.addr];
      end
    end

    assign bus.rdata[g*LANE_W +: LANE_W] = rd_q;
  end

endmodule : pss_core

`default_nettype wire

// *** hw/pss_port.sv ***
// Function
// - Qualifier high freezes all internal state
// - Qualifier high never deselects the device
// - Capture data inputs on rising edge
// - Read data is the addressed location
// - Drive only with output enable low
// - Float on write data, deselect, restart
// - Strap high interleaved, low linear burst
// - Open strap reads high; keep constant
// - Sleep input idles device, keeps data
// - Register all inputs and outputs
// - Access starts only with all selects
// - Load low and selected latches address
// - Write request picks read or write
// - Write only selected byte lanes
// - Writes are self-timed internally
// - All operations are pipelined
// - Write request active low, edge sampled
// - Advance high steps burst counter
// - Lane selects active low, gate parity
// - Selects: low, high, low active
//
// Purpose: Access pipeline of a pipelined burst SRAM behind its pins
// Assumes: All inputs synchronous to clk; rst only clears control state
// Notes:   Read data drives after the second recognised edge
`timescale 1ns/10ps
`default_nettype none
`include "pss_map.svh"

module pss_port #(
  parameter int ADDR_W = `PSS_ADDR_W,
  parameter int LANES  = `PSS_LANES
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           clk_qualify_n,
  input  wire logic                           chip_sel_a_n,
  input  wire logic                           chip_sel_b,
  input  wire logic                           chip_sel_c_n,
  input  wire logic                           advance_or_load,
  input  wire logic                           wr_req_n,
  input  wire logic [LANES-1:0]               byte_lane_sel_n,
  input  wire logic [ADDR_W-1:0]              addr,
  input  wire logic                           burst_mode,
  input  wire logic                           sleep_req,
  input  wire logic                           out_drive_n,
  input  wire logic [LANES*`PSS_BYTE_W-1:0]   data_in,
  output logic      [LANES*`PSS_BYTE_W-1:0]   data_out,
  output logic                                data_oe,
  input  wire logic [LANES-1:0]               lane_parity_in,
  output logic      [LANES-1:0]               lane_parity_out,
  output logic                                lane_parity_oe,
  output logic                                asleep
);
  import pss_pkg::*;

  localparam int BW     = `PSS_BURST_W;
  localparam int BYTE_W = `PSS_BYTE_W;
  localparam int LANE_W = `PSS_LANE_W;

  logic                ce;
  logic                sel;
  logic                sleep_meta_q;
  logic                asleep_q;
  logic                burst_act_q;
  logic                burst_ilv_q;
  pss_op_e             burst_op_q;
  pss_burst_t          burst_start_q;
  pss_burst_t          burst_cnt_q;
  pss_burst_t          burst_cnt_d;
  pss_burst_t          burst_seq;
  pss_op_e             s1_op_q;
  pss_op_e             s1_op_d;
  logic [ADDR_W-1:0]   s1_addr_q;
  logic [ADDR_W-1:0]   s1_addr_d;
  logic [LANES-1:0]    s1_lane_n_q;
  pss_op_e             s2_op_q;
  logic [ADDR_W-1:0]   s2_addr_q;
  logic [LANES-1:0]    s2_lane_n_q;
  logic                drive_q;

  pss_core_if #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) core_bus ();

  // A masked edge is simply not an edge for any register below
  assign ce  = ~clk_qualify_n;
  assign sel = ~chip_sel_a_n & chip_sel_b & ~chip_sel_c_n;

  // Two stages give the two-cycle entry and exit of sleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_meta_q <= 1'b0;
      asleep_q     <= 1'b0;
    end else if (ce) begin
      sleep_meta_q <= sleep_req;
      asleep_q     <= sleep_meta_q;
    end
  end

  // Burst counter only touches the two low address bits
  assign burst_cnt_d = burst_cnt_q + `PSS_BURST_ONE;
  assign burst_seq   = burst_ilv_q ? (burst_start_q ^ burst_cnt_d)
                                   : (burst_start_q + burst_cnt_d);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_act_q   <= 1'b0;
      burst_ilv_q   <= 1'b1;
      burst_op_q    <= OP_NOP;
      burst_start_q <= `PSS_BURST_RST;
      burst_cnt_q   <= `PSS_BURST_RST;
    end else if (ce) begin
      if (asleep_q) begin
        burst_act_q <= 1'b0;
      end else if (!advance_or_load) begin
        burst_act_q   <= sel;
        burst_op_q    <= wr_req_n ? OP_RD : OP_WR;
        burst_start_q <= addr[BW-1:0];
        burst_cnt_q   <= `PSS_BURST_RST;
        burst_ilv_q   <= burst_mode;
      end else if (burst_act_q) begin
        burst_cnt_q <= burst_cnt_d;
      end
    end
  end

  // Command decode at a recognised edge
  always_comb begin
    s1_op_d   = OP_NOP;
    s1_addr_d = s1_addr_q;
    if (asleep_q) begin
      s1_op_d = OP_NOP;
    end else if (!advance_or_load) begin
      if (sel) begin
        s1_op_d   = wr_req_n ? OP_RD : OP_WR;
        s1_addr_d = addr;
      end
    end else if (burst_act_q) begin
      // Selects and write request are ignored while advancing
      s1_op_d   = burst_op_q;
      s1_addr_d = {s1_addr_q[ADDR_W-1:BW], burst_seq};
    end
    // Advance with no burst open stays idle; a load is expected
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_op_q     <= OP_NOP;
      s1_addr_q   <= '0;
      s1_lane_n_q <= '1;
    end else if (ce) begin
      s1_op_q     <= s1_op_d;
      s1_addr_q   <= s1_addr_d;
      s1_lane_n_q <= byte_lane_sel_n;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s2_op_q     <= OP_NOP;
      s2_addr_q   <= '0;
      s2_lane_n_q <= '1;
    end else if (ce) begin
      s2_op_q     <= s1_op_q;
      s2_addr_q   <= s1_addr_q;
      s2_lane_n_q <= s1_lane_n_q;
    end
  end

  // Data phase: the array and its read register act at the second edge
  assign core_bus.rd_en   = ce && (s2_op_q == OP_RD);
  assign core_bus.wr_en   = ce && (s2_op_q == OP_WR);
  assign core_bus.addr    = s2_addr_q;
  assign core_bus.lane_we = ~s2_lane_n_q;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign core_bus.wdata[g*LANE_W +: LANE_W] =
      {lane_parity_in[g], data_in[g*BYTE_W +: BYTE_W]};
    assign data_out[g*BYTE_W +: BYTE_W] = core_bus.rdata[g*LANE_W +: BYTE_W];
    assign lane_parity_out[g] = core_bus.rdata[g*LANE_W + BYTE_W];
  end

  pss_core #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_core (
    .clk (clk),
    .bus (core_bus)
  );

  // Output enable is sampled, trading the asynchronous path for a clean flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_q <= `PSS_OE_RST;
    end else if (ce) begin
      case (s2_op_q)
        OP_RD:   drive_q <= ~out_drive_n;
        OP_WR:   drive_q <= 1'b0;
        default: drive_q <= 1'b0;
      endcase
    end
  end

  assign data_oe        = drive_q;
  assign lane_parity_oe = drive_q;
  assign asleep         = asleep_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_freeze_hold: assert property (!ce |=> $stable(s1_op_q) && $stable(s2_op_q)
      && $stable(drive_q) && $stable(burst_cnt_q) && $stable(s1_addr_q))
    else $error("State changed on a masked edge");

  chk_load_addr: assert property (ce && !advance_or_load && sel && !asleep_q
      |=> s1_addr_q == $past(addr))
    else $error("Address not latched on load");

  chk_op_type: assert property (ce && !advance_or_load && sel && !asleep_q
      |=> s1_op_q == ($past(wr_req_n) ? OP_RD : OP_WR))
    else $error("Wrong access type loaded");

  chk_desel_idle: assert property (ce && !advance_or_load && !sel
      |=> s1_op_q == OP_NOP)
    else $error("Access started without all selects");

  chk_read_pipe: assert property ((ce && s1_op_q == OP_RD) ##1 (ce && !out_drive_n)
      |=> drive_q)
    else $error("Read data not driven two edges after address");

  chk_oe_gate: assert property ($rose(drive_q) |-> $past(!out_drive_n)
      && $past(s2_op_q) == OP_RD)
    else $error("Drive rose without enable or read");

  chk_write_float: assert property (ce && s2_op_q == OP_WR |=> !drive_q)
    else $error("Driving during write data phase");

  chk_desel_float: assert property (ce && s2_op_q == OP_NOP |=> !drive_q)
    else $error("Driving while deselected");

  chk_lane_mask: assert property ((ce && s1_op_q == OP_WR) ##1 ce
      |-> core_bus.wr_en && core_bus.lane_we == ~$past(s1_lane_n_q))
    else $error("Write lanes do not follow lane selects");

  chk_burst_hold: assert property (ce && advance_or_load && burst_act_q && !asleep_q
      |=> s1_op_q == $past(burst_op_q)
      && s1_addr_q[ADDR_W-1:BW] == $past(s1_addr_q[ADDR_W-1:BW]))
    else $error("Burst changed type or upper address");

  chk_burst_ilv: assert property ((ce && !advance_or_load && sel && !asleep_q
      && burst_mode && addr[BW-1:0] == 2'h1) ##1 (ce && advance_or_load && !asleep_q)
      |=> s1_addr_q[BW-1:0] == 2'h0)
    else $error("Interleaved order broken");

  chk_burst_lin: assert property ((ce && !advance_or_load && sel && !asleep_q
      && !burst_mode && addr[BW-1:0] == 2'h1) ##1 (ce && advance_or_load && !asleep_q)
      |=> s1_addr_q[BW-1:0] == 2'h2)
    else $error("Linear order broken");

  chk_sleep_block: assert property (asleep_q && ce |=> s1_op_q == OP_NOP)
    else $error("Access accepted while asleep");

  // Sleep follows its request by two recognised edges, in and out
  chk_sleep_entry: assert property ((ce && sleep_req) ##1 ce |=> asleep_q)
    else $error("Sleep not entered two edges after request");

  chk_sleep_exit: assert property ((ce && !sleep_req) ##1 ce |=> !asleep_q)
    else $error("Sleep not left two edges after release");

  chk_sleep_close: assert property (ce && asleep_q |=> !burst_act_q)
    else $error("Burst left open while asleep");

  chk_desel_burst: assert property (ce && !advance_or_load && !sel && !asleep_q
      |=> !burst_act_q)
    else $error("Burst opened by a deselect");

  // An advance with nothing open must not replay a stale command
  chk_adv_idle: assert property (ce && advance_or_load && !burst_act_q
      |=> s1_op_q == OP_NOP)
    else $error("Advance started an access with no burst open");

  chk_burst_wrap: assert property (ce && advance_or_load && burst_act_q && !asleep_q
      && burst_cnt_q == 2'h3
      |=> s1_addr_q[BW-1:0] == $past(burst_start_q))
    else $error("Burst did not wrap to its start");

  chk_beat_lanes: assert property (ce && advance_or_load && burst_act_q && !asleep_q
      |=> s1_lane_n_q == $past(byte_lane_sel_n))
    else $error("Lane selects not taken on a burst beat");

  chk_drive_off: assert property (ce && out_drive_n |=> !drive_q)
    else $error("Driving with output enable high");

  cov_read: cover property (ce && s2_op_q == OP_RD ##1 drive_q);
  cov_write: cover property (core_bus.wr_en && core_bus.lane_we != '1);
  cov_burst: cover property (ce && advance_or_load && burst_act_q && burst_cnt_q == 2'h3);
  cov_sleep: cover property ($rose(asleep_q));
  cov_stall: cover property (!ce ##1 (ce && s2_op_q == OP_RD));

endmodule : pss_port

`default_nettype wire

// *** include/pss_core_if.sv ***
// Purpose: Port between the access pipeline and the storage array
// Assumes: Enables already carry the clock qualifier
// Notes:   Read data comes from the array's output register
`timescale 1ns/10ps
`default_nettype none
`include "pss_map.svh"

interface pss_core_if #(
  parameter int ADDR_W = `PSS_ADDR_W,
  parameter int LANES  = `PSS_LANES,
  parameter int LANE_W = `PSS_LANE_W
) ();
  logic                    rd_en;
  logic                    wr_en;
  logic [ADDR_W-1:0]       addr;
  logic [LANES-1:0]        lane_we;
  logic [LANES*LANE_W-1:0] wdata;
  logic [LANES*LANE_W-1:0] rdata;

  modport ctrl (output rd_en, output wr_en, output addr, output lane_we, output wdata,
                input rdata);
  modport core (input rd_en, input wr_en, input addr, input lane_we, input wdata,
                output rdata);
endinterface : pss_core_if

`default_nettype wire

// *** include/pss_map.svh ***
// Purpose: Widths and reset values of the pipelined synchronous SRAM port
// Assumes: One lane is one data byte plus its parity bit
// Notes:   Definitions only
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

`define PSS_ADDR_W    18
`define PSS_LANES     4
`define PSS_BYTE_W    8
`define PSS_LANE_W    9
`define PSS_BURST_W   2
`define PSS_BURST_ONE 2'h1
`define PSS_BURST_RST 2'h0
`define PSS_OE_RST    1'b0

`endif

// *** include/pss_pkg.sv ***
// Purpose: Shared types of the pipelined synchronous SRAM port
// Assumes: Widths come from pss_map.svh
// Notes:   Types only
`include "pss_map.svh"

package pss_pkg;

  typedef enum logic [1:0] {OP_NOP, OP_RD, OP_WR} pss_op_e;

  typedef logic [`PSS_BURST_W-1:0] pss_burst_t;

endpackage : pss_pkg

// *** tb/pss_master.sv ***
// Purpose: Bus master model driving the SRAM port pins
// Assumes: Pins change on the falling clock edge only
// Notes:   Keeps a word model and queues one expected result per command
`timescale 1ns/10ps
`default_nettype none

module pss_master (
  input  wire logic        clk,
  output logic             clk_qualify_n,
  output logic [2:0]       sel,
  output logic             advance_or_load,
  output logic             wr_req_n,
  output logic [3:0]       byte_lane_sel_n,
  output logic [17:0]      addr,
  output logic             burst_mode,
  output logic             sleep_req,
  output logic             out_drive_n,
  output logic [35:0]      wd
);
  import pss_pkg::*;
  typedef struct packed {logic rd; logic [35:0] v;} pss_note_s;
  pss_note_s         note_q[$];
  logic [35:0]       mem[logic [17:0]];
  logic [35:0]       wd1, wd2;
  logic [17:0]       base;
  logic [1:0]        beat;
  logic              mode, rd, mute, open;

  initial begin
    // Qualifier high through reset, so no edge counts before the first command
    {clk_qualify_n, sel, advance_or_load, wr_req_n, byte_lane_sel_n} = {1'b1, 3'b101, 2'b01, 4'hf};
    {addr, wd, wd1, wd2, mute, open} = '0;
    {burst_mode, sleep_req, out_drive_n} = 3'b100;
  end

  task automatic set_pins(input logic bm, input logic od, input logic sl, input logic mu);
    {burst_mode, out_drive_n, sleep_req, mute} = {bm, od, sl, mu};
  endtask : set_pins

  task automatic cmd(input logic [2:0] s, input logic adv, input logic wn,
                     input logic [3:0] ln, input logic [17:0] a, input logic [35:0] d);
    logic [17:0] ea;
    logic        on;
    @(negedge clk);
    {clk_qualify_n, sel, advance_or_load, wr_req_n} = {1'b0, s, adv, wn};
    {byte_lane_sel_n, addr, wd, wd2, wd1} = {ln, a, wd2, wd1, d};
    on = !mute && (adv ? open : s == 3'b010);
    if (!adv) {base, beat, mode, rd, open} = {a, 2'h0, burst_mode, wn, on};
    else {beat, open} = {beat + 2'h1, on};
    ea = {base[17:2], mode ? base[1:0] ^ beat : base[1:0] + beat};
    if (on && !rd) for (int g = 0; g < 4; g++) if (!ln[g])
      {mem[ea][32+g], mem[ea][8*g+:8]} = {d[32+g], d[8*g+:8]};
    note_q.push_back(pss_note_s'{on && rd, (on && rd) ? mem[ea] : 36'h0_0000_0000});
  endtask : cmd

  task automatic stall(input int n);
    repeat (n) begin
      @(negedge clk);
      {clk_qualify_n, sel, advance_or_load, wr_req_n} = {1'b1, 5'($urandom)};
      {addr, wd} = 54'({$urandom, $urandom});
    end
  endtask : stall
endmodule : pss_master

`default_nettype wire

// *** tb/test_pipelined_sync_sram_port.sv ***
// Purpose: Self-checking bench of the SRAM port against a bus master model
// Assumes: Results arrive two recognised edges after their command
// Notes:   Monitor pops one note per recognised edge
`timescale 1ns/10ps
`default_nettype none

module test_pipelined_sync_sram_port;
  import pss_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, rec, prev_oe, adv, wn, cq_n, bm, sl, od, oe, poe, zz;
  logic [2:0]  sel;
  logic [3:0]  ln, pout;
  logic [17:0] a;
  logic [35:0] wd;
  logic [31:0] dout;
  logic [36:0] n;
  int          mismatches = 0, comparisons = 0, seen = 0;

  always #12.5 clk = ~clk;

  pss_master m (.clk(clk), .clk_qualify_n(cq_n), .sel(sel), .advance_or_load(adv),
    .wr_req_n(wn), .byte_lane_sel_n(ln), .addr(a), .burst_mode(bm), .sleep_req(sl),
    .out_drive_n(od), .wd(wd));
  pss_port dut (.clk(clk), .rst(rst), .clk_qualify_n(cq_n), .chip_sel_a_n(sel[2]),
    .chip_sel_b(sel[1]), .chip_sel_c_n(sel[0]), .advance_or_load(adv), .wr_req_n(wn),
    .byte_lane_sel_n(ln), .addr(a), .burst_mode(bm), .sleep_req(sl), .out_drive_n(od),
    .data_in(wd[31:0]), .data_out(dout), .data_oe(oe), .lane_parity_in(wd[35:32]),
    .lane_parity_out(pout), .lane_parity_oe(poe), .asleep(zz));

  task automatic cmp(input string what, input logic [35:0] exp, input logic [35:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  // Outputs are judged 1 ns after the edge so the design's updates have landed
  always @(posedge clk) begin
    rec = !rst && cq_n === 1'b0;
    #1;
    if (rec && seen >= 2) begin
      n = m.note_q.pop_front();
      cmp("drive", 36'(n[36] & ~od), 36'(oe));
      cmp("parity drive", 36'(n[36] & ~od), 36'(poe));
      if (n[36] && !od) cmp("read data", n[35:0], {pout, dout});
    end else if (!rec && seen >= 2) cmp("held drive", 36'(prev_oe), 36'(oe));
    if (rec) seen++;
    prev_oe = oe;
  end

  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    void'($urandom(32'h0000_ea3a));
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    for (int i = 0; i < 8; i++) m.cmd(3'b010, 0, 0, 4'h0, 18'(i), 36'({$urandom, $urandom}));
    for (int i = 0; i < 12; i++)
      m.cmd(i % 2 ? 3'b010 : 3'(12'h0c6 >> (i % 3) * 3), 0, 1, 4'hf, 18'(i / 2), '0);
    $display("test fill done");
    for (int g = 0; g < 4; g++) begin
      m.cmd(3'b010, 0, 0, ~(4'h1 << g), 18'h3, 36'({$urandom, $urandom}));
      m.cmd(3'b010, 0, 1, 4'hf, 18'h3, '0);
    end
    $display("test lanes done");
    for (int md = 0; md < 2; md++) begin
      m.set_pins(1'(md), 0, 0, 0);
      m.cmd(3'b000, 0, 1, 4'hf, '0, '0);
      m.cmd(3'b010, 0, 0, 4'h0, 18'h5, 36'({$urandom, $urandom}));
      repeat (3) m.cmd(3'($urandom), 1, 1'($urandom), 4'($urandom), 18'($urandom), 36'({$urandom, $urandom}));
      m.cmd(3'b010, 0, 1, 4'hf, 18'h6, '0);
      repeat (4) m.cmd(3'($urandom), 1, 1'($urandom), 4'hf, 18'($urandom), '0);
    end
    $display("test burst done");
    m.cmd(3'b010, 0, 1, 4'hf, 18'h2, '0);
    m.stall(3);
    m.cmd(3'b010, 0, 0, 4'h0, 18'h2, 36'({$urandom, $urandom}));
    m.stall(2);
    m.cmd(3'b010, 0, 1, 4'hf, 18'h2, '0);
    m.set_pins(1, 1, 0, 0);
    repeat (3) m.cmd(3'b010, 0, 1, 4'hf, 18'h1, '0);
    m.set_pins(1, 0, 0, 0);
    $display("test qualify done");
    repeat (40) m.cmd($urandom_range(3) ? 3'b010 : 3'($urandom), 0, 1'($urandom), 4'($urandom),
                      18'($urandom_range(7)), 36'({$urandom, $urandom}));
    $display("test random done");
    m.cmd(3'b110, 0, 1, 4'hf, '0, '0);
    m.set_pins(1, 0, 1, 0);
    repeat (3) m.cmd(3'b110, 0, 1, 4'hf, '0, '0);
    @(posedge clk) #2 cmp("asleep", 36'h1, 36'(zz));
    m.set_pins(1, 0, 1, 1);
    m.cmd(3'b010, 0, 0, 4'h0, 18'h0, 36'({$urandom, $urandom}));
    m.set_pins(1, 0, 0, 1);
    repeat (3) m.cmd(3'b110, 0, 1, 4'hf, '0, '0);
    @(posedge clk) #2 cmp("awake", 36'h0, 36'(zz));
    m.set_pins(1, 0, 0, 0);
    m.cmd(3'b010, 0, 1, 4'hf, 18'h0, '0);
    m.cmd(3'b011, 0, 1, 4'hf, '0, '0);
    repeat (2) m.cmd(3'b010, 1, 1, 4'hf, '0, '0);
    repeat (3) m.cmd(3'b011, 0, 1, 4'hf, '0, '0);
    $display("test sleep done");
    test_done();
  end
endmodule : test_pipelined_sync_sram_port

`default_nettype wire
